// *** rtl/vcc_pkg.sv ***
`default_nettype none
package vcc_pkg;
  // Register addresses on the microport
  localparam logic [2:0] ADDR_STG  = 3'h1;
  localparam logic [2:0] ADDR_PATH = 3'h2;
  localparam logic [2:0] ADDR_PMS  = 3'h3;
  localparam logic [2:0] ADDR_CCK  = 3'h4;
  localparam logic [2:0] ADDR_CCH  = 3'h5;
  localparam logic [2:0] ADDR_SCH  = 3'h6;
  localparam logic [2:0] ADDR_LOOP = 3'h7;
  // Values after reset
  localparam logic [7:0] RST_STG   = 8'h00;
  localparam logic [7:0] RST_PATH  = 8'h00;
  localparam logic [7:0] RST_PMS   = 8'hc0;
  localparam logic [7:0] RST_CCK   = 8'h02;
  localparam logic [7:0] RST_CCH   = 8'hff;
  localparam logic [7:0] RST_SCH   = 8'hff;
  localparam logic [7:0] RST_LOOP  = 8'h00;
  // Writable bits, reserved bits read zero
  localparam logic [7:0] MASK_STG  = 8'h07;
  localparam logic [7:0] MASK_PATH = 8'h01;
  localparam logic [7:0] MASK_PMS  = 8'hef;
  localparam logic [7:0] MASK_SRST = 8'h20;
  localparam logic [7:0] MASK_LOOP = 8'h0c;
  // Field positions
  localparam int IFPD_BIT  = 7;
  localparam int DRPD_BIT  = 6;
  localparam int SRST_BIT  = 5;
  localparam int TXM_BIT   = 3;
  localparam int RXM_BIT   = 2;
  localparam int TXSEL_BIT = 1;
  localparam int RXSEL_BIT = 0;
  localparam int SUM_BIT   = 0;
  localparam int CEN_BIT   = 7;
  localparam int DEN_BIT   = 6;
  localparam int RATE_BIT  = 5;
  localparam int ALAW_BIT  = 4;
  localparam int SMAG_BIT  = 3;
  localparam int LTYPE_BIT = 3;
  localparam int LEN_BIT   = 2;
  localparam logic [2:0] CSL_BUS = 3'h7;
  // Codes
  localparam logic [7:0] QUIET_SM = 8'h80;
  localparam logic [7:0] ADI_MASK = 8'h55;
  // Microport framing
  localparam logic [2:0] PORT_IDLE     = 3'h2;
  localparam logic [3:0] PORT_CMD_LAST = 4'h7;
  localparam logic [3:0] PORT_LAST     = 4'hf;
  localparam int         CMD_READ_BIT  = 7;
  // Link framing
  localparam logic [4:0] CH_SIG    = 5'h00;
  localparam logic [4:0] CH_CTL    = 5'h01;
  localparam logic [4:0] CH_B1     = 5'h02;
  localparam logic [7:0] POS_DONE  = 8'h1f;
  localparam logic [7:0] SLOT_BITS = 8'h08;
  typedef struct packed {
    logic bus_mode;
    logic ifpd;
    logic drpd;
    logic control_channel_enable;
    logic signalling_channel_enable;
    logic rate8;
    logic txsel;
    logic rxsel;
    logic loop_dig;
  } vcc_cfg_type;
  typedef struct packed {
    logic [7:0] voice;
    logic [7:0] ctl;
    logic [7:0] sig;
  } vcc_bytes_type;
  localparam vcc_bytes_type BYTES_RESET = {8'h80, 8'hff, 8'hff};
endpackage
`default_nettype wire

// *** rtl/vcc_control_registers.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Sidetone gain zero is off, else steps
// - Summing bit adds sidetone into receive path
// - Interface power-down bit, set after reset
// - Driver power-down; bus mode voice slot floats
// - Strobed mode power-down sends zero code
// - Driver and codec active when both low
// - Software reset acts like reset, bit stays
// - Transmit mute sends quiet code outward
// - Receive mute feeds quiet code inward
// - Transmit channel select B2 high, B1 low
// - Receive channel select B2 high, B1 low
// - Control channel sent in channel 1
// - Received channel 1 always readable
// - Signalling sends two bits in channel 0 at 16k, one at 8k
// - Signalling rate 8k high, 16k low
// - Law bit: A-law high, mu-law low
// - Code assignment sign-magnitude or standard
// - Clock select picks mode and rates
// - Signalling register only while access valid
// - Digital loopback input straight to output
// - Analog loopback routes microphone to speaker
// - Loop type ignored without loop enable
// - Reset holds others low, two writes needed
module vcc_control_registers (
  // System clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Serial microport pins
  input  wire logic       port_sclk_i,
  input  wire logic       port_select_n_i,
  input  wire logic       port_data_i,
  output logic            port_data_o,
  output logic            port_data_oe_o,
  output logic            signalling_access_n_o,
  // Serial bus link
  input  wire logic       link_clk_i,
  input  wire logic       frame_strobe_i,
  input  wire logic       bus_serial_input_i,
  output logic            bus_serial_output_o,
  output logic            bus_serial_output_oe_o,
  // Codec side
  input  wire logic [7:0] tx_code_i,
  output logic [7:0]      rx_code_o,
  output logic            sidetone_enable_o,
  output logic [2:0]      sidetone_gain_o,
  output logic            sidetone_sum_o,
  output logic            interface_power_down_o,
  output logic            driver_power_down_o,
  output logic            codec_power_down_o,
  output logic            a_law_o,
  output logic            sign_magnitude_o,
  output logic [2:0]      clock_select_o,
  output logic            bus_mode_o,
  output logic            loop_digital_o,
  output logic            loop_analog_o
);

  // Standard coding is its own inverse, so one function serves both paths
  function automatic logic [7:0] vcc_code(input logic [7:0] c,
                                          input logic       alaw,
                                          input logic       smag);
    if (smag)
      vcc_code = c;
    else if (alaw)
      vcc_code = c ^ vcc_pkg::ADI_MASK;
    else
      vcc_code = {c[7], ~c[6:0]};
  endfunction

  logic [7:0]              sidetone_gain_field;
  logic [7:0]              path;
  logic [7:0]              pms;
  logic [7:0]              cck;
  logic [7:0]              cch;
  logic [7:0]              sch;
  logic [7:0]              loopr;
  logic [2:0]              ps1;
  logic [2:0]              ps2;
  logic [2:0]              ps3;
  logic [2:0]              pf;
  logic [3:0]              pcnt;
  logic [7:0]              cmd;
  logic [7:0]              wsh;
  logic [7:0]              osh;
  logic                    rd_act;
  logic                    t1;
  logic                    t2;
  logic                    t3;
  logic                    rx_tog;
  vcc_pkg::vcc_bytes_type  snap;
  vcc_pkg::vcc_cfg_type    cfg_q;
  vcc_pkg::vcc_cfg_type    next_cfg;
  vcc_pkg::vcc_bytes_type  next_snap;
  vcc_pkg::vcc_bytes_type  rx_l;

  // Reset and mode decode
  wire       soft_rst  = pms[vcc_pkg::SRST_BIT];
  wire       hold      = reset_i | soft_rst;
  wire       bus_mode  = cck[2:0] == vcc_pkg::CSL_BUS;
  wire       alaw      = cck[vcc_pkg::ALAW_BIT];
  wire       smag      = cck[vcc_pkg::SMAG_BIT];
  wire [7:0] quiet     = vcc_code(vcc_pkg::QUIET_SM, alaw, smag);

  // Microport pin filter: a change counts once stages two and three agree
  wire [2:0] agree     = ~(ps2 ^ ps3);
  wire [2:0] next_pf   = (agree & ps3) | (~agree & pf);
  wire       sck_rise  = next_pf[0] & ~pf[0];
  wire       sck_fall  = ~next_pf[0] & pf[0];
  wire       sel       = ~pf[1];
  wire       din       = pf[2];
  wire [7:0] cmd_full  = {cmd[6:0], din};
  wire [7:0] wr_data   = {wsh[6:0], din};
  wire       cmd_done  = sel & sck_rise & (pcnt == vcc_pkg::PORT_CMD_LAST);
  wire       wr_en     = sel & sck_rise & (pcnt == vcc_pkg::PORT_LAST)
                         & ~cmd[vcc_pkg::CMD_READ_BIT];
  wire [2:0] wr_addr   = cmd[2:0];
  wire       rd_en     = cmd_done & cmd_full[vcc_pkg::CMD_READ_BIT];
  wire [2:0] rd_addr   = cmd_full[2:0];
  wire [7:0] wsel      = wr_en ? (8'h01 << wr_addr) : 8'h00;
  wire       shift_out = sck_fall & rd_act & pcnt[3];

  // Read mux; address zero is not mapped and reads zero
  wire [7:0] rd_word =
    (rd_addr == vcc_pkg::ADDR_STG)  ? sidetone_gain_field :
    (rd_addr == vcc_pkg::ADDR_PATH) ? path :
    (rd_addr == vcc_pkg::ADDR_PMS)  ? pms :
    (rd_addr == vcc_pkg::ADDR_CCK)  ? cck :
    (rd_addr == vcc_pkg::ADDR_CCH)  ? rx_l.ctl :
    (rd_addr == vcc_pkg::ADDR_SCH)  ? rx_l.sig :
    (rd_addr == vcc_pkg::ADDR_LOOP) ? loopr : 8'h00;

  // Signalling access window
  wire       rx_ev   = t2 ^ t3;
  wire       sig_ok  = bus_mode & ~signalling_access_n_o;
  wire       sig_set = rx_ev & bus_mode;
  wire       sig_clr = (rd_en & (rd_addr == vcc_pkg::ADDR_SCH))
                       | wsel[vcc_pkg::ADDR_SCH];
  wire       set_rst = wsel[vcc_pkg::ADDR_PMS] & wr_data[vcc_pkg::SRST_BIT];
  // While in software reset only the reset bit may change
  wire [7:0] next_pms = (soft_rst | set_rst) ? (wr_data & vcc_pkg::MASK_SRST)
                        : (wr_data & vcc_pkg::MASK_PMS);
  wire [7:0] next_rx  = pms[vcc_pkg::RXM_BIT] ? vcc_pkg::QUIET_SM
                        : vcc_code(rx_l.voice, alaw, smag);
  wire       tx_quiet = pms[vcc_pkg::TXM_BIT] | pms[vcc_pkg::DRPD_BIT];

  always_comb begin
    next_snap.voice = tx_quiet ? quiet : vcc_code(tx_code_i, alaw, smag);
    next_snap.ctl   = cch;
    next_snap.sig   = sch;
    next_cfg.bus_mode = bus_mode;
    next_cfg.ifpd     = pms[vcc_pkg::IFPD_BIT];
    next_cfg.drpd     = pms[vcc_pkg::DRPD_BIT];
    next_cfg.control_channel_enable      = cck[vcc_pkg::CEN_BIT];
    next_cfg.signalling_channel_enable      = cck[vcc_pkg::DEN_BIT];
    next_cfg.rate8    = cck[vcc_pkg::RATE_BIT];
    next_cfg.txsel    = pms[vcc_pkg::TXSEL_BIT];
    next_cfg.rxsel    = pms[vcc_pkg::RXSEL_BIT];
    next_cfg.loop_dig = loopr[vcc_pkg::LEN_BIT] & loopr[vcc_pkg::LTYPE_BIT];
  end

  // Microport pin synchronisers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ps1 <= vcc_pkg::PORT_IDLE;
      ps2 <= vcc_pkg::PORT_IDLE;
      ps3 <= vcc_pkg::PORT_IDLE;
      pf  <= vcc_pkg::PORT_IDLE;
    end else begin
      ps1 <= {port_data_i, port_select_n_i, port_sclk_i};
      ps2 <= ps1;
      ps3 <= ps2;
      pf  <= next_pf;
    end
  end

  // Microport shifter: command byte then data byte, MSB first
  always_ff @(posedge clk_i) begin
    if (reset_i | ~sel) begin
      pcnt           <= 4'h0;
      cmd            <= 8'h00;
      wsh            <= 8'h00;
      osh            <= 8'h00;
      rd_act         <= 1'b0;
      port_data_o    <= 1'b0;
      port_data_oe_o <= 1'b0;
    end else begin
      port_data_oe_o <= rd_act & pcnt[3];
      if (sck_rise) begin
        pcnt <= pcnt + 4'h1;
        if (pcnt[3])
          wsh <= wr_data;
        else
          cmd <= cmd_full;
        if (cmd_done) begin
          osh    <= rd_word;
          rd_act <= cmd_full[vcc_pkg::CMD_READ_BIT];
        end
      end else if (shift_out) begin
        port_data_o <= osh[7];
        osh         <= {osh[6:0], 1'b0};
      end
    end
  end

  // Power, mute and select register
  always_ff @(posedge clk_i) begin
    if (reset_i)
      pms <= vcc_pkg::RST_PMS;
    else if (wsel[vcc_pkg::ADDR_PMS])
      pms <= next_pms;
  end

  // Remaining registers: held at reset values during either reset
  always_ff @(posedge clk_i) begin
    if (hold) begin
      sidetone_gain_field   <= vcc_pkg::RST_STG;
      path  <= vcc_pkg::RST_PATH;
      cck   <= vcc_pkg::RST_CCK;
      cch   <= vcc_pkg::RST_CCH;
      sch   <= vcc_pkg::RST_SCH;
      loopr <= vcc_pkg::RST_LOOP;
    end else begin
      if (wsel[vcc_pkg::ADDR_STG])
        sidetone_gain_field <= wr_data & vcc_pkg::MASK_STG;
      if (wsel[vcc_pkg::ADDR_PATH])
        path <= wr_data & vcc_pkg::MASK_PATH;
      if (wsel[vcc_pkg::ADDR_CCK])
        cck <= wr_data;
      if (wsel[vcc_pkg::ADDR_CCH])
        cch <= wr_data;
      if (wsel[vcc_pkg::ADDR_SCH] & sig_ok)
        sch <= wr_data;
      if (wsel[vcc_pkg::ADDR_LOOP])
        loopr <= wr_data & vcc_pkg::MASK_LOOP;
    end
  end

  // Frame event from the link, snapshot of outgoing bytes
  // Snapshot only moves just after bit 31 of a bus frame or the strobed voice byte ends, so the link reads it stable
  always_ff @(posedge clk_i) begin
    if (hold) begin
      t1    <= 1'b0;
      t2    <= 1'b0;
      t3    <= 1'b0;
      snap  <= vcc_pkg::BYTES_RESET;
      // Track the registers, so the link never sees power-up after reset
      cfg_q <= next_cfg;
    end else begin
      t1    <= rx_tog;
      t2    <= t1;
      t3    <= t2;
      cfg_q <= next_cfg;
      if (rx_ev)
        snap <= next_snap;
    end
  end

  // Access window: a new frame wins over a host access in the same cycle
  always_ff @(posedge clk_i) begin
    if (hold)
      signalling_access_n_o <= 1'b1;
    else if (sig_set)
      signalling_access_n_o <= 1'b0;
    else if (sig_clr)
      signalling_access_n_o <= 1'b1;
  end

  // Control outputs to the analog side
  always_ff @(posedge clk_i) begin
    sidetone_enable_o      <= |sidetone_gain_field[2:0];
    sidetone_gain_o        <= sidetone_gain_field[2:0];
    sidetone_sum_o         <= path[vcc_pkg::SUM_BIT];
    interface_power_down_o <= pms[vcc_pkg::IFPD_BIT];
    driver_power_down_o    <= pms[vcc_pkg::IFPD_BIT] | pms[vcc_pkg::DRPD_BIT];
    codec_power_down_o     <= pms[vcc_pkg::IFPD_BIT] | pms[vcc_pkg::DRPD_BIT];
    a_law_o                <= alaw;
    sign_magnitude_o       <= smag;
    clock_select_o         <= cck[2:0];
    bus_mode_o             <= bus_mode;
    loop_digital_o         <= loopr[vcc_pkg::LEN_BIT] & loopr[vcc_pkg::LTYPE_BIT];
    loop_analog_o          <= loopr[vcc_pkg::LEN_BIT] & ~loopr[vcc_pkg::LTYPE_BIT];
    if (hold)
      rx_code_o <= vcc_pkg::QUIET_SM;
    else if (rx_ev)
      rx_code_o <= next_rx;
  end

  // ---------------- Link clock domain ----------------
  logic                    lr1;
  logic                    lr2;
  vcc_pkg::vcc_cfg_type    lc1;
  vcc_pkg::vcc_cfg_type    lc2;
  logic                    fq;
  logic                    act;
  logic [7:0]              pos;
  logic [7:0]              ish;
  vcc_pkg::vcc_bytes_type  tx_l;
  vcc_pkg::vcc_bytes_type  txw;

  // Settings are quasi-static levels; a write lands within a frame or two
  always_ff @(posedge link_clk_i) begin
    lr1 <= hold;
    lr2 <= lr1;
    lc1 <= cfg_q;
    lc2 <= lc1;
  end

  wire       lrst     = lr2;
  wire       fs       = lc2.bus_mode ? frame_strobe_i : frame_strobe_i & ~fq;
  wire [7:0] next_pos = fs ? 8'h00 : pos + 8'h01;
  wire [4:0] chan     = next_pos[7:3];
  wire [2:0] bi       = 3'h7 - next_pos[2:0];
  assign     txw      = fs ? snap : tx_l;
  wire [7:0] vbyte    = lc2.loop_dig ? rx_l.voice : txw.voice;
  wire       sig_bit  = (bi == 3'h7) ? txw.sig[7] :
                        ((bi == 3'h6) & ~lc2.rate8) ? txw.sig[6] : 1'b1;
  wire       in_slot  = frame_strobe_i & (next_pos < vcc_pkg::SLOT_BITS);
  wire       ch_sig   = lc2.bus_mode & (chan == vcc_pkg::CH_SIG) & lc2.signalling_channel_enable;
  wire       ch_ctl   = lc2.bus_mode & (chan == vcc_pkg::CH_CTL) & lc2.control_channel_enable;
  wire [4:0] tx_ch    = vcc_pkg::CH_B1 + {4'h0, lc2.txsel};
  wire       ch_v     = lc2.bus_mode ? (chan == tx_ch) & ~lc2.drpd : in_slot;
  wire       next_oe  = ~lc2.ifpd & (ch_sig | ch_ctl | ch_v);
  wire       next_out = ch_sig ? sig_bit : ch_ctl ? txw.ctl[bi] : vbyte[bi];
  wire [7:0] ibyte    = {ish[6:0], bus_serial_input_i};
  wire       byte_end = pos[2:0] == 3'h7;
  wire [4:0] ichan    = pos[7:3];
  wire [4:0] rx_ch    = vcc_pkg::CH_B1 + {4'h0, lc2.rxsel};
  wire       v_end    = lc2.bus_mode ? byte_end & (ichan == rx_ch) : act & byte_end;
  wire       f_end    = lc2.bus_mode ? pos == vcc_pkg::POS_DONE : act & byte_end;

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      fq                     <= 1'b0;
      act                    <= 1'b0;
      rx_tog                 <= 1'b0;
      pos                    <= 8'h00;
      ish                    <= 8'h00;
      tx_l                   <= vcc_pkg::BYTES_RESET;
      rx_l                   <= vcc_pkg::BYTES_RESET;
      bus_serial_output_o    <= 1'b1;
      bus_serial_output_oe_o <= 1'b0;
    end else begin
      fq                     <= frame_strobe_i;
      act                    <= in_slot;
      pos                    <= next_pos;
      ish                    <= ibyte;
      bus_serial_output_o    <= next_out;
      bus_serial_output_oe_o <= next_oe;
      if (fs)
        tx_l <= snap;
      if (lc2.bus_mode & byte_end & (ichan == vcc_pkg::CH_SIG))
        rx_l.sig <= ibyte;
      if (lc2.bus_mode & byte_end & (ichan == vcc_pkg::CH_CTL))
        rx_l.ctl <= ibyte;
      if (v_end)
        rx_l.voice <= ibyte;
      if (f_end)
        rx_tog <= ~rx_tog;
    end
  end

  // ---------------- Checks ----------------
  sequence rst_write_s;
    set_rst & ~reset_i;
  endsequence

  sequence rst_settle_s;
    soft_rst ##1 (cck == vcc_pkg::RST_CCK) && (cch == vcc_pkg::RST_CCH)
      && (loopr == vcc_pkg::RST_LOOP) && (sidetone_gain_field == vcc_pkg::RST_STG);
  endsequence

  rst_defaults_a :
    assert property (@(posedge clk_i) disable iff (reset_i)
      rst_write_s |=> rst_settle_s)
      else $error("Software reset did not restore defaults");

  soft_hold_a :
    assert property (@(posedge clk_i) disable iff (reset_i)
      soft_rst |-> (pms & ~vcc_pkg::MASK_SRST) == 8'h00)
      else $error("Control bits not held low in software reset");

  st_off_a :
    assert property (@(posedge clk_i) disable iff (reset_i)
      wsel[vcc_pkg::ADDR_STG] && !hold && (wr_data[2:0] == 3'h0)
      |=> ##1 !sidetone_enable_o)
      else $error("Sidetone not off after zero gain write");

  drv_active_a :
    assert property (@(posedge clk_i) disable iff (reset_i)
      !driver_power_down_o |-> $past(pms[7:6]) == 2'h0)
      else $error("Driver active with a power-down bit set");

  rx_mute_a :
    assert property (@(posedge clk_i) disable iff (hold)
      rx_ev && pms[vcc_pkg::RXM_BIT] |=> rx_code_o == vcc_pkg::QUIET_SM)
      else $error("Receive mute did not give quiet code");

  tx_mute_a :
    assert property (@(posedge clk_i) disable iff (hold)
      rx_ev && pms[vcc_pkg::TXM_BIT] |=> snap.voice == $past(quiet))
      else $error("Transmit mute did not give quiet code");

  sig_refuse_a :
    assert property (@(posedge clk_i) disable iff (hold)
      wsel[vcc_pkg::ADDR_SCH] && !sig_ok |=> $stable(sch))
      else $error("Signalling write taken outside access window");

  loop_off_a :
    assert property (@(posedge clk_i) disable iff (reset_i)
      !loopr[vcc_pkg::LEN_BIT] |=> !loop_digital_o && !loop_analog_o)
      else $error("Loopback active without enable");

  link_pd_a :
    assert property (@(posedge link_clk_i) disable iff (lrst)
      lc2.ifpd |=> !bus_serial_output_oe_o)
      else $error("Serial output driven while interface powered down");

  ctl_slot_a :
    assert property (@(posedge link_clk_i) disable iff (lrst)
      lc2.bus_mode && !lc2.control_channel_enable && (chan == vcc_pkg::CH_CTL)
      |=> !bus_serial_output_oe_o)
      else $error("Control channel driven while disabled");

endmodule
`default_nettype wire

// *** bench/vcc_link_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module vcc_link_partner (
  // Link clock
  input  wire logic       link_clk_i,
  // Bytes to send in channels 0 and 1
  input  wire logic [7:0] sig_in_i,
  input  wire logic [7:0] ctl_in_i,
  // Device output
  input  wire logic       serial_i,
  input  wire logic       serial_oe_i,
  // Drive toward device
  output logic            frame_strobe_o,
  output logic            serial_o,
  // Captured bytes
  output logic [7:0]      sig_seen_o,
  output logic [7:0]      ctl_seen_o,
  output logic            ctl_oe_o
);
  logic [7:0] pos;
  initial begin
    pos = 8'h00;
    frame_strobe_o = 1'b0;
    serial_o = 1'b0;
    sig_seen_o = 8'h00;
    ctl_seen_o = 8'h00;
    ctl_oe_o = 1'b0;
  end
  // Frame pulse 256 bits apart, bits change just after the edge
  always @(posedge link_clk_i) begin
    pos = pos + 8'h01;
    #3;
    frame_strobe_o = (pos == 8'hff);
    if (pos < 8'h08) serial_o = sig_in_i[3'h7 - pos[2:0]];
    else if (pos < 8'h10) serial_o = ctl_in_i[3'h7 - pos[2:0]];
    else serial_o = pos[0] ^ pos[3];
  end
  // Output bit is settled by mid-bit
  always @(negedge link_clk_i) begin
    if (pos < 8'h08) sig_seen_o[3'h7 - pos[2:0]] = serial_i;
    if (pos >= 8'h08 && pos < 8'h10) begin
      ctl_seen_o[3'h7 - pos[2:0]] = serial_i;
      ctl_oe_o = (pos == 8'h08) ? serial_oe_i : (ctl_oe_o & serial_oe_i);
    end
  end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i, reset_i, sclk, sel_n, pd, lclk, strobe, sin;
  logic port_data_o, port_data_oe_o, signalling_access_n_o, sout, sout_oe;
  logic [7:0] tx_code, rx_code_o, ctl_seen, sig_seen, ctl_in, sig_in, v, d, rd_val;
  logic sidetone_enable_o, sidetone_sum_o, interface_power_down_o, driver_power_down_o;
  logic codec_power_down_o, a_law_o, sign_magnitude_o, bus_mode_o, ctl_oe;
  logic loop_digital_o, loop_analog_o;
  logic [2:0] sidetone_gain_o, clock_select_o;
  logic [7:0] exp_q[$];
  logic [7:0] dflt [8];
  int err_total, n_compared, seed, i, k;
  event rd_ev;

  vcc_control_registers vcc_control_registers_inst (
    .clk_i(clk_i), .reset_i(reset_i), .port_sclk_i(sclk), .port_select_n_i(sel_n),
    .port_data_i(pd), .port_data_o(port_data_o), .port_data_oe_o(port_data_oe_o),
    .signalling_access_n_o(signalling_access_n_o), .link_clk_i(lclk),
    .frame_strobe_i(strobe), .bus_serial_input_i(sin), .bus_serial_output_o(sout),
    .bus_serial_output_oe_o(sout_oe), .tx_code_i(tx_code), .rx_code_o(rx_code_o),
    .sidetone_enable_o(sidetone_enable_o), .sidetone_gain_o(sidetone_gain_o),
    .sidetone_sum_o(sidetone_sum_o), .interface_power_down_o(interface_power_down_o),
    .driver_power_down_o(driver_power_down_o), .codec_power_down_o(codec_power_down_o),
    .a_law_o(a_law_o), .sign_magnitude_o(sign_magnitude_o),
    .clock_select_o(clock_select_o), .bus_mode_o(bus_mode_o),
    .loop_digital_o(loop_digital_o), .loop_analog_o(loop_analog_o));

  vcc_link_partner vcc_link_partner_inst (
    .link_clk_i(lclk), .sig_in_i(sig_in), .ctl_in_i(ctl_in), .serial_i(sout),
    .serial_oe_i(sout_oe), .frame_strobe_o(strobe), .serial_o(sin),
    .sig_seen_o(sig_seen), .ctl_seen_o(ctl_seen), .ctl_oe_o(ctl_oe));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #24 lclk = ~lclk;
  end

  task automatic report_and_stop;
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    n_compared++;
    if (seen !== expv) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  // Slow bit-banging: every pin change must clear the input filter
  task automatic xfer(input logic [15:0] w, output logic [7:0] r);
    r = 8'h00;
    sel_n = 1'b0;
    for (int b = 0; b < 16; b++) begin
      pd = w[15-b];
      tick(8);
      sclk = 1'b1;
      tick(8);
      sclk = 1'b0;
      tick(8);
      if (b >= 7 && b <= 14) begin
        r[14-b] = port_data_o;
        check({7'h00, port_data_oe_o}, {7'h00, w[15]});
      end
    end
    tick(8);
    sel_n = 1'b1;
    tick(8);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] dv);
    logic [7:0] junk;
    xfer({5'h00, a, dv}, junk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    xfer({5'h10, a, 8'h00}, rd_val);
    -> rd_ev;
  endtask

  always @(rd_ev) check(rd_val, exp_q.pop_front());

  initial begin
    #4000000;
    err_total++;
    report_and_stop();
  end

  initial begin
    err_total = 0;
    n_compared = 0;
    seed = 31104;
    reset_i = 1'b1;
    sclk = 1'b0;
    sel_n = 1'b1;
    pd = 1'b0;
    tx_code = $random(seed);
    ctl_in = $random(seed);
    sig_in = $random(seed);
    dflt = '{8'h00, 8'h00, 8'h00, 8'hc0, 8'h02, 8'hff, 8'hff, 8'h00};
    tick(12);
    reset_i = 1'b0;
    tick(4);
    for (i = 0; i < 8; i++) rd(i[2:0], dflt[i]);
    check({2'h0, bus_mode_o, interface_power_down_o, clock_select_o, 1'b0}, 8'h14);
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      v[2:0] = i[2:0];
      wr(vcc_pkg::ADDR_STG, v);
      rd(vcc_pkg::ADDR_STG, {5'h00, v[2:0]});
      check({4'h0, sidetone_enable_o, sidetone_gain_o}, {4'h0, i != 0, v[2:0]});
    end
    v = $random(seed);
    wr(vcc_pkg::ADDR_PATH, v);
    rd(vcc_pkg::ADDR_PATH, {7'h00, v[0]});
    check({7'h00, sidetone_sum_o}, {7'h00, v[0]});
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      v[3:2] = i[1:0];
      wr(vcc_pkg::ADDR_LOOP, v);
      rd(vcc_pkg::ADDR_LOOP, {4'h0, v[3:2], 2'h0});
      check({6'h00, loop_digital_o, loop_analog_o}, {6'h00, v[3] & v[2], ~v[3] & v[2]});
    end
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      v[2:0] = i[2:0];
      wr(vcc_pkg::ADDR_CCK, v);
      rd(vcc_pkg::ADDR_CCK, v);
      check({2'h0, bus_mode_o, a_law_o, sign_magnitude_o, clock_select_o},
            {2'h0, i == 7, v[4], v[3], v[2:0]});
    end
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      v = {i[1:0], 2'h0, v[3:0]};
      wr(vcc_pkg::ADDR_PMS, v);
      rd(vcc_pkg::ADDR_PMS, v);
      check({5'h00, interface_power_down_o, driver_power_down_o, codec_power_down_o},
            {5'h00, v[7], v[7] | v[6], v[7] | v[6]});
    end
    // Software reset: other bits held low, second write needed
    wr(vcc_pkg::ADDR_PMS, 8'hef);
    rd(vcc_pkg::ADDR_PMS, 8'h20);
    wr(vcc_pkg::ADDR_STG, 8'h05);
    rd(vcc_pkg::ADDR_STG, 8'h00);
    rd(vcc_pkg::ADDR_CCK, 8'h02);
    wr(vcc_pkg::ADDR_PMS, 8'h0f);
    rd(vcc_pkg::ADDR_PMS, 8'h00);
    wr(vcc_pkg::ADDR_PMS, 8'h0f);
    rd(vcc_pkg::ADDR_PMS, 8'h0f);
    // Bus mode with both channels on
    wr(vcc_pkg::ADDR_PMS, 8'h00);
    wr(vcc_pkg::ADDR_CCK, 8'hc7);
    v = $random(seed);
    wr(vcc_pkg::ADDR_CCH, v);
    for (k = 0; k < 2000 && signalling_access_n_o !== 1'b0; k++) tick(1);
    if (k == 2000) begin
      err_total++;
      report_and_stop();
    end
    d = $random(seed);
    wr(vcc_pkg::ADDR_SCH, d);
    tick(1500);
    check(ctl_seen, v);
    check({7'h00, ctl_oe}, 8'h01);
    check(sig_seen, {d[7:6], 6'h3f});
    check(rx_code_o, 8'h2a);
    rd(vcc_pkg::ADDR_CCH, ctl_in);
    rd(vcc_pkg::ADDR_SCH, sig_in);
    // Control channel off, signalling at the slower rate
    wr(vcc_pkg::ADDR_CCK, 8'h67);
    tick(1500);
    check({7'h00, ctl_oe}, 8'h00);
    check(sig_seen, {d[7], 1'b1, 6'h3f});
    rd(vcc_pkg::ADDR_CCH, ctl_in);
    wr(vcc_pkg::ADDR_PMS, 8'h04);
    tick(600);
    check(rx_code_o, 8'h80);
    report_and_stop();
  end
endmodule
`default_nettype wire
